// file: inc/xmap_pkg.sv
package xmap_pkg;

  // ---------------------------------------------------------------
  // direct register offsets (serial map)
  // ---------------------------------------------------------------
  localparam int ADR_W = 7;
  localparam logic [6:0] ADR_NULL = 7'h00;
  localparam logic [6:0] ADR_WR_TGT = 7'h01;
  localparam logic [6:0] ADR_WR_HI = 7'h02;
  localparam logic [6:0] ADR_WR_LO = 7'h03;
  localparam logic [6:0] ADR_WR_CTL = 7'h04;
  localparam logic [6:0] ADR_RD_TGT = 7'h05;
  localparam logic [6:0] ADR_RD_CTL = 7'h06;
  localparam logic [6:0] ADR_RD_HI = 7'h07;
  localparam logic [6:0] ADR_RD_LO = 7'h08;
  localparam logic [6:0] ADR_ERR = 7'h0f;

  // ---------------------------------------------------------------
  // control register fields and reset values
  // ---------------------------------------------------------------
  localparam int GO_BIT = 15;
  localparam int BUSY_BIT = 8;
  localparam int DONE_BIT = 0;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [7:0] TGT_RST = 8'h00;

  // ---------------------------------------------------------------
  // extended address ranges
  // ---------------------------------------------------------------
  localparam logic [7:0] EE_LAST = 8'h3f;
  localparam logic [7:0] SH_FIRST = 8'h40;
  localparam logic [7:0] SH_LAST = 8'h7f;
  localparam logic [7:0] MISC_FIRST = 8'h80;
  localparam logic [7:0] MISC_LAST = 8'haa;
  localparam int EE_DEPTH = 64;
  localparam int SH_DEPTH = 64;
  localparam int MISC_DEPTH = 43;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int EE_WR_TIME_NS = 6500000;
  localparam int EE_RD_TIME_NS = 2000;
  localparam int EE_WR_CYC = (EE_WR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EE_RD_CYC = (EE_RD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // serial frame: 1 write flag, 7 address bits, 16 data bits
  // ---------------------------------------------------------------
  localparam int FRAME_BITS = 24;
  localparam logic [4:0] FRAME_LAST = 5'h17;

  typedef struct packed {
    logic wr;
    logic [6:0] addr;
    logic [15:0] data;
  } xmap_frame_t;

  typedef enum logic [1:0] {
    XMAP_EE = 2'b00,
    XMAP_SH = 2'b01,
    XMAP_MISC = 2'b11,
    XMAP_NONE = 2'b10
  } xmap_region_t;

  typedef enum logic {
    XMAP_IDLE = 1'b0,
    XMAP_RUN = 1'b1
  } xmap_eng_t;

endpackage : xmap_pkg

// file: verilog/xmap_spi_link.sv
`timescale 1ns/1ps
module xmap_spi_link (
  input wire logic rst,
  input wire logic sclk,
  input wire logic spi_cs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  input wire logic [15:0] resp_word,
  output xmap_pkg::xmap_frame_t frame,
  output logic frame_tgl
);

  logic [4:0] bit_cnt_r;
  logic [22:0] rx_sh_r;
  logic [15:0] tx_sh_r;

  // ---------------------------------------------------------------
  // bit counter, cleared by the frame select itself
  // ---------------------------------------------------------------
  always_ff @(posedge sclk or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      bit_cnt_r <= 5'h00;
    end else if (bit_cnt_r != xmap_pkg::FRAME_LAST + 5'h01) begin
      bit_cnt_r <= bit_cnt_r + 5'h01;
    end
  end

  // shift in mosi, shift out the previous answer
  always_ff @(posedge sclk) begin
    rx_sh_r <= {rx_sh_r[21:0], mosi};
    if (bit_cnt_r == 5'h00) begin
      tx_sh_r <= {resp_word[14:0], 1'b0};
    end else begin
      tx_sh_r <= {tx_sh_r[14:0], 1'b0};
    end
  end

  // capture a whole frame and signal it by a toggle
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      frame <= '0;
      frame_tgl <= 1'b0;
    end else if (!spi_cs_n && bit_cnt_r == xmap_pkg::FRAME_LAST) begin
      frame <= {rx_sh_r, mosi};
      frame_tgl <= ~frame_tgl;
    end
  end

  // miso drives only while selected
  assign miso = (bit_cnt_r == 5'h00) ? resp_word[15] : tx_sh_r[15];
  assign miso_oe = ~spi_cs_n;

endmodule : xmap_spi_link

// file: verilog/xmap_ext_mem.sv
`timescale 1ns/1ps
// Behaviour
// RULE_01 - a write target of 00-3f goes to eeprom, 40-7f to shadow, 80-aa to misc space.
// RULE_02 - an eeprom write takes about 6.5 ms and the host waits for it before relying on it.
// RULE_03 - the write word is high register upper byte, high lower, low upper, low lower.
// RULE_04 - writing 1 to write control bit 15 launches a write, sets busy and clears done.
// RULE_05 - the write start bit is write-only and always reads 0.
// RULE_06 - write done at bit 0 sets on completion and clears on the next start.
// RULE_07 - write busy at bit 8 reads 1 while a write runs.
// RULE_08 - read targets use the same three ranges and an eeprom read takes about 2 us.
// RULE_09 - writing 1 to read control bit 15 launches a read, sets busy, clears done, reads 0.
// RULE_10 - read busy at bit 8 reads 1 while a read runs.
// RULE_11 - fetched bits 31:24 and 23:16 land in the high read-data register.
// RULE_12 - fetched bits 15:0 land in the low read-data register, 15:8 in its upper byte.
// RULE_13 - a read of the error register copies its old value into the low read-data register; the code skips the copy when a read finishes in that cycle.
// RULE_14 - address 00 is a null register that always reads zero.
// RULE_15 - read done at bit 0 sets on completion and clears when a read starts.
// RULE_16 - the host loads address and data first and waits for done before a new start.
// RULE_17 - upper target bits and unused control bits read as zero.
module xmap_ext_mem #(
  parameter int WR_EE_CYCLES = xmap_pkg::EE_WR_CYC,
  parameter int RD_EE_CYCLES = xmap_pkg::EE_RD_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic sclk,
  input wire logic spi_cs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  input wire logic [15:0] err_word,
  output logic err_clear,
  output logic ext_write_busy,
  output logic ext_read_busy
);

  localparam int CNT_W = $clog2(WR_EE_CYCLES + RD_EE_CYCLES + 1);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  xmap_pkg::xmap_frame_t frame;
  logic frame_tgl;
  logic tgl_s1_r, tgl_s2_r, tgl_s3_r;
  logic frame_stb, host_wr, host_rd;
  logic [15:0] resp_r, rd_value;

  logic [7:0] wr_tgt_r, rd_tgt_r;
  logic [15:0] wr_hi_r, wr_lo_r, rd_hi_r, rd_lo_r;
  logic ext_write_done_r, ext_read_done_r;
  xmap_pkg::xmap_eng_t wr_state_r, wr_state_nxt, rd_state_r, rd_state_nxt;
  logic [CNT_W-1:0] wr_cnt_r, rd_cnt_r;
  logic ext_write_go, ext_read_go, wr_finish, rd_finish;
  logic [31:0] wr_word, rd_word;
  xmap_pkg::xmap_region_t wr_region, rd_region;

  logic [31:0] ee_mem [xmap_pkg::EE_DEPTH];
  logic [31:0] sh_mem [xmap_pkg::SH_DEPTH];
  logic [31:0] misc_mem [xmap_pkg::MISC_DEPTH];

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // sort an extended address into its memory space
  function automatic xmap_pkg::xmap_region_t region_of(input logic [7:0] a);
    if (a <= xmap_pkg::EE_LAST) begin
      return xmap_pkg::XMAP_EE;
    end else if (a <= xmap_pkg::SH_LAST) begin
      return xmap_pkg::XMAP_SH;
    end else if (a <= xmap_pkg::MISC_LAST) begin
      return xmap_pkg::XMAP_MISC;
    end
    return xmap_pkg::XMAP_NONE;
  endfunction : region_of

  // busy and done packed into a control word; the start bit stays zero
  function automatic logic [15:0] ctl_word(input logic busy, input logic done);
    logic [15:0] w;
    w = xmap_pkg::WORD_RST;
    w[xmap_pkg::BUSY_BIT] = busy;
    w[xmap_pkg::DONE_BIT] = done;
    return w;
  endfunction : ctl_word

  // counter load for an operation in a given space: its busy cycles minus one
  function automatic logic [CNT_W-1:0] run_len(input xmap_pkg::xmap_region_t r,
                                               input int ee_cycles);
    if (r == xmap_pkg::XMAP_EE) begin
      return CNT_W'(ee_cycles - 1);
    end
    return '0;
  endfunction : run_len

  // ---------------------------------------------------------------
  // serial link on its own clock
  // ---------------------------------------------------------------
  xmap_spi_link u_link (
    .rst(rst),
    .sclk(sclk),
    .spi_cs_n(spi_cs_n),
    .mosi(mosi),
    .miso(miso),
    .miso_oe(miso_oe),
    .resp_word(resp_r),
    .frame(frame),
    .frame_tgl(frame_tgl)
  );

  // ---------------------------------------------------------------
  // frame crossing
  // ---------------------------------------------------------------
  // toggle synchroniser; the frame word is stable until the next frame
  always_ff @(posedge clock) begin
    if (rst) begin
      tgl_s1_r <= 1'b0;
      tgl_s2_r <= 1'b0;
      tgl_s3_r <= 1'b0;
    end else begin
      tgl_s1_r <= frame_tgl;
      tgl_s2_r <= tgl_s1_r;
      tgl_s3_r <= tgl_s2_r;
    end
  end

  assign frame_stb = tgl_s2_r ^ tgl_s3_r;
  assign host_wr = frame_stb & frame.wr;
  assign host_rd = frame_stb & ~frame.wr;

  // ---------------------------------------------------------------
  // host-written registers
  // ---------------------------------------------------------------
  // targets and write word; upper target bits are not stored
  always_ff @(posedge clock) begin
    if (rst) begin
      wr_tgt_r <= xmap_pkg::TGT_RST;
      rd_tgt_r <= xmap_pkg::TGT_RST;
      wr_hi_r <= xmap_pkg::WORD_RST;
      wr_lo_r <= xmap_pkg::WORD_RST;
    end else if (host_wr) begin
      unique case (frame.addr)
        xmap_pkg::ADR_WR_TGT: wr_tgt_r <= frame.data[7:0]; // RULE_17
        xmap_pkg::ADR_WR_HI: wr_hi_r <= frame.data;
        xmap_pkg::ADR_WR_LO: wr_lo_r <= frame.data;
        xmap_pkg::ADR_RD_TGT: rd_tgt_r <= frame.data[7:0]; // RULE_17
        default: ;
      endcase
    end
  end

  // start strobes; a start during a running operation is ignored
  assign ext_write_go = host_wr && frame.addr == xmap_pkg::ADR_WR_CTL
                        && frame.data[xmap_pkg::GO_BIT]
                        && wr_state_r == xmap_pkg::XMAP_IDLE; // RULE_04
  assign ext_read_go = host_wr && frame.addr == xmap_pkg::ADR_RD_CTL
                       && frame.data[xmap_pkg::GO_BIT]
                       && rd_state_r == xmap_pkg::XMAP_IDLE; // RULE_09

  // ---------------------------------------------------------------
  // write engine
  // ---------------------------------------------------------------
  assign wr_region = region_of(wr_tgt_r); // RULE_01
  assign wr_word = {wr_hi_r[15:8], wr_hi_r[7:0], wr_lo_r[15:8], wr_lo_r[7:0]}; // RULE_03
  assign wr_finish = wr_state_r == xmap_pkg::XMAP_RUN && wr_cnt_r == '0;

  // write state selection
  always_comb begin
    wr_state_nxt = wr_state_r;
    unique case (wr_state_r)
      xmap_pkg::XMAP_IDLE: if (ext_write_go) wr_state_nxt = xmap_pkg::XMAP_RUN;
      xmap_pkg::XMAP_RUN: if (wr_finish) wr_state_nxt = xmap_pkg::XMAP_IDLE;
    endcase
  end

  // write state and duration counter
  always_ff @(posedge clock) begin
    if (rst) begin
      wr_state_r <= xmap_pkg::XMAP_IDLE;
      wr_cnt_r <= '0;
    end else begin
      wr_state_r <= wr_state_nxt;
      if (ext_write_go) begin
        wr_cnt_r <= run_len(wr_region, WR_EE_CYCLES); // RULE_02
      end else if (wr_cnt_r != '0) begin
        wr_cnt_r <= wr_cnt_r - CNT_W'(1);
      end
    end
  end

  // write done flag: cleared by start, set by completion
  always_ff @(posedge clock) begin
    if (rst) begin
      ext_write_done_r <= 1'b0;
    end else if (wr_finish) begin
      ext_write_done_r <= 1'b1; // RULE_06
    end else if (ext_write_go) begin
      ext_write_done_r <= 1'b0; // RULE_04
    end
  end

  assign ext_write_busy = wr_state_r == xmap_pkg::XMAP_RUN; // RULE_07

  // commit the word to its space at completion
  always_ff @(posedge clock) begin
    if (wr_finish) begin
      unique case (wr_region)
        xmap_pkg::XMAP_EE: ee_mem[wr_tgt_r[5:0]] <= wr_word; // RULE_01
        xmap_pkg::XMAP_SH: sh_mem[wr_tgt_r[5:0]] <= wr_word;
        xmap_pkg::XMAP_MISC: misc_mem[6'(wr_tgt_r - xmap_pkg::MISC_FIRST)] <= wr_word;
        xmap_pkg::XMAP_NONE: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // read engine
  // ---------------------------------------------------------------
  assign rd_region = region_of(rd_tgt_r); // RULE_08
  assign rd_finish = rd_state_r == xmap_pkg::XMAP_RUN && rd_cnt_r == '0;

  // fetch from the selected space; out of range reads zero
  always_comb begin
    rd_word = '0;
    unique case (rd_region)
      xmap_pkg::XMAP_EE: rd_word = ee_mem[rd_tgt_r[5:0]];
      xmap_pkg::XMAP_SH: rd_word = sh_mem[rd_tgt_r[5:0]];
      xmap_pkg::XMAP_MISC: rd_word = misc_mem[6'(rd_tgt_r - xmap_pkg::MISC_FIRST)];
      xmap_pkg::XMAP_NONE: rd_word = '0;
    endcase
  end

  // read state selection
  always_comb begin
    rd_state_nxt = rd_state_r;
    unique case (rd_state_r)
      xmap_pkg::XMAP_IDLE: if (ext_read_go) rd_state_nxt = xmap_pkg::XMAP_RUN;
      xmap_pkg::XMAP_RUN: if (rd_finish) rd_state_nxt = xmap_pkg::XMAP_IDLE;
    endcase
  end

  // read state and duration counter
  always_ff @(posedge clock) begin
    if (rst) begin
      rd_state_r <= xmap_pkg::XMAP_IDLE;
      rd_cnt_r <= '0;
    end else begin
      rd_state_r <= rd_state_nxt;
      if (ext_read_go) begin
        rd_cnt_r <= run_len(rd_region, RD_EE_CYCLES); // RULE_08
      end else if (rd_cnt_r != '0) begin
        rd_cnt_r <= rd_cnt_r - CNT_W'(1);
      end
    end
  end

  // read done flag: cleared by start, set by completion
  always_ff @(posedge clock) begin
    if (rst) begin
      ext_read_done_r <= 1'b0;
    end else if (rd_finish) begin
      ext_read_done_r <= 1'b1; // RULE_15
    end else if (ext_read_go) begin
      ext_read_done_r <= 1'b0; // RULE_09
    end
  end

  assign ext_read_busy = rd_state_r == xmap_pkg::XMAP_RUN; // RULE_10

  // read data registers; a finishing read wins over an error snapshot
  always_ff @(posedge clock) begin
    if (rst) begin
      rd_hi_r <= xmap_pkg::WORD_RST;
      rd_lo_r <= xmap_pkg::WORD_RST;
    end else if (rd_finish) begin
      rd_hi_r <= {rd_word[31:24], rd_word[23:16]}; // RULE_11
      rd_lo_r <= {rd_word[15:8], rd_word[7:0]}; // RULE_12
    end else if (host_rd && frame.addr == xmap_pkg::ADR_ERR) begin
      rd_lo_r <= err_word; // RULE_13
    end
  end

  // error register is cleared by the read that snapshots it
  assign err_clear = host_rd && frame.addr == xmap_pkg::ADR_ERR; // RULE_13

  // ---------------------------------------------------------------
  // register readback
  // ---------------------------------------------------------------
  // value seen by a host read of the frame's address
  always_comb begin
    rd_value = xmap_pkg::WORD_RST;
    unique case (frame.addr)
      xmap_pkg::ADR_NULL: rd_value = xmap_pkg::WORD_RST; // RULE_14
      xmap_pkg::ADR_WR_TGT: rd_value = {8'h00, wr_tgt_r}; // RULE_17
      xmap_pkg::ADR_WR_HI: rd_value = wr_hi_r;
      xmap_pkg::ADR_WR_LO: rd_value = wr_lo_r;
      xmap_pkg::ADR_WR_CTL: rd_value = ctl_word(ext_write_busy, ext_write_done_r); // RULE_05
      xmap_pkg::ADR_RD_TGT: rd_value = {8'h00, rd_tgt_r}; // RULE_17
      xmap_pkg::ADR_RD_CTL: rd_value = ctl_word(ext_read_busy, ext_read_done_r); // RULE_09
      xmap_pkg::ADR_RD_HI: rd_value = rd_hi_r;
      xmap_pkg::ADR_RD_LO: rd_value = rd_lo_r;
      xmap_pkg::ADR_ERR: rd_value = err_word;
      default: rd_value = xmap_pkg::WORD_RST;
    endcase
  end

  // answer word shifted out during the following frame
  always_ff @(posedge clock) begin
    if (rst) begin
      resp_r <= xmap_pkg::WORD_RST;
    end else if (host_rd) begin
      resp_r <= rd_value;
    end
  end

endmodule : xmap_ext_mem

// file: sim/xmap_ext_mem_props.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// port checker for the extended access engine
// ---------------------------------------------------------------
module xmap_ext_mem_chk #(
  parameter int WR_EE_CYCLES = 40,
  parameter int RD_EE_CYCLES = 20
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic sclk,
  input wire logic spi_cs_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic [15:0] err_word,
  input wire logic err_clear,
  input wire logic ext_write_busy,
  input wire logic ext_read_busy
);
  logic [31:0] wr_cnt_r;
  logic [31:0] rd_cnt_r;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // length of the current write busy run
  always_ff @(posedge clock) begin
    if (rst || !ext_write_busy) wr_cnt_r <= 32'h0;
    else wr_cnt_r <= wr_cnt_r + 32'h1;
  end

  // length of the current read busy run
  always_ff @(posedge clock) begin
    if (rst || !ext_read_busy) rd_cnt_r <= 32'h0;
    else rd_cnt_r <= rd_cnt_r + 32'h1;
  end

  // snapshot strobe is a single clock wide
  sequence s_clr_pulse;
    err_clear ##1 !err_clear;
  endsequence

  // link idle: frame closed, pin released
  sequence s_bus_idle;
    spi_cs_n && !miso_oe;
  endsequence

  chk_oe_cs: assert property (miso_oe == !spi_cs_n)
    else $error("serial output enable does not follow select");
  chk_clr_pulse: assert property (err_clear |-> s_clr_pulse)
    else $error("error clear strobe longer than one clock");
  chk_clr_idle: assert property (err_clear |-> s_bus_idle)
    else $error("error clear strobe inside a frame");
  chk_wr_start: assert property ($rose(ext_write_busy) |-> s_bus_idle)
    else $error("write started inside a frame");
  chk_rd_start: assert property ($rose(ext_read_busy) |-> s_bus_idle)
    else $error("read started inside a frame");
  chk_wr_len: assert property ($fell(ext_write_busy) |-> (wr_cnt_r <= 32'h2) ||
    (wr_cnt_r >= WR_EE_CYCLES && wr_cnt_r <= WR_EE_CYCLES + 1))
    else $error("write busy run has a wrong length");
  chk_rd_len: assert property ($fell(ext_read_busy) |-> (rd_cnt_r <= 32'h2) ||
    (rd_cnt_r >= RD_EE_CYCLES && rd_cnt_r <= RD_EE_CYCLES + 1))
    else $error("read busy run has a wrong length");
  chk_wr_bound: assert property (wr_cnt_r <= WR_EE_CYCLES + 1)
    else $error("write busy held too long");
  chk_rd_bound: assert property (rd_cnt_r <= RD_EE_CYCLES + 1)
    else $error("read busy held too long");
  chk_rst_quiet: assert property ($fell(rst) |-> !ext_write_busy && !ext_read_busy)
    else $error("engine busy right after reset");
endmodule : xmap_ext_mem_chk

bind xmap_ext_mem xmap_ext_mem_chk #(
  .WR_EE_CYCLES(WR_EE_CYCLES),
  .RD_EE_CYCLES(RD_EE_CYCLES)
) u_chk (
  .clock(clock), .rst(rst), .sclk(sclk), .spi_cs_n(spi_cs_n), .mosi(mosi),
  .miso(miso), .miso_oe(miso_oe), .err_word(err_word), .err_clear(err_clear),
  .ext_write_busy(ext_write_busy), .ext_read_busy(ext_read_busy)
);

// file: sim/xmap_spi_host.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// serial host model: mode 0 frames, 64 ns link clock
// ---------------------------------------------------------------
module xmap_spi_host (
  output logic sclk,
  output logic spi_cs_n,
  output logic mosi,
  input wire logic miso,
  input wire logic miso_oe,
  output logic [15:0] rx_word,
  output logic rx_valid
);
  // link clock stands still and select is high outside frames
  initial begin
    sclk = 1'b0;
    spi_cs_n = 1'b1;
    mosi = 1'b0;
    rx_word = 16'h0000;
    rx_valid = 1'b0;
  end

  // one frame; the first 16 bits back are the previous answer
  task automatic xfer(input logic wr, input logic [6:0] addr, input logic [15:0] data,
    input logic want);
    xmap_pkg::xmap_frame_t f;
    logic [15:0] rx;
    f = {wr, addr, data};
    rx = 16'h0000;
    spi_cs_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      mosi = f[i];
      #32;
      if (i >= 8) rx[i - 8] = miso;
      sclk = 1'b1;
      #32;
      sclk = 1'b0;
    end
    #32;
    spi_cs_n = 1'b1;
    mosi = ~mosi; // no stale bit left on the line
    #600;
    if (want) begin
      rx_word = rx;
      rx_valid = 1'b1;
      #1;
      rx_valid = 1'b0;
    end
  endtask : xfer
endmodule : xmap_spi_host

// file: sim/xmap_ext_mem_tb.sv
`timescale 1ns/1ps
module xmap_ext_mem_tb;
  logic clock;
  logic rst;
  logic sclk;
  logic spi_cs_n;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic [15:0] err_word;
  logic err_clear;
  logic ext_write_busy;
  logic ext_read_busy;
  logic [15:0] rx_word;
  logic rx_valid;
  logic [31:0] seed;
  logic [15:0] exp_q[$];
  logic [7:0] tgts [7] = '{8'h40, 8'h00, 8'haa, 8'h3f, 8'h7f, 8'h80, 8'hab};
  int bad_count = 0;
  int n_compared = 0;
  int clr_seen = 0;

  xmap_ext_mem #(.WR_EE_CYCLES(40), .RD_EE_CYCLES(20)) uut (
    .clock(clock), .rst(rst), .sclk(sclk), .spi_cs_n(spi_cs_n), .mosi(mosi),
    .miso(miso), .miso_oe(miso_oe), .err_word(err_word), .err_clear(err_clear),
    .ext_write_busy(ext_write_busy), .ext_read_busy(ext_read_busy)
  );

  xmap_spi_host u_host (
    .sclk(sclk), .spi_cs_n(spi_cs_n), .mosi(mosi), .miso(miso),
    .miso_oe(miso_oe), .rx_word(rx_word), .rx_valid(rx_valid)
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift

  task automatic fail(input logic [15:0] got, input logic [15:0] exp);
    bad_count++;
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
  endtask : fail

  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) fail(got, exp);
  endtask : cmp16

  task automatic cmp1(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) fail({15'h0, got}, {15'h0, exp});
  endtask : cmp1

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  task automatic wr_reg(input logic [6:0] a, input logic [15:0] d);
    @(negedge clock);
    u_host.xfer(1'b1, a, d, 1'b0);
  endtask : wr_reg

  // read frame, then a null frame that carries the answer back
  task automatic rd_reg(input logic [6:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    @(negedge clock);
    u_host.xfer(1'b0, a, 16'h0000, 1'b0);
    u_host.xfer(1'b0, xmap_pkg::ADR_NULL, 16'h0000, 1'b1);
  endtask : rd_reg

  task automatic wait_idle();
    int i;
    for (i = 0; i < 500; i++) begin
      @(negedge clock);
      if (!ext_write_busy && !ext_read_busy) break;
    end
    if (i == 500) begin
      fail(16'h0001, 16'h0000);
      tally_and_finish();
    end
  endtask : wait_idle

  // answers are checked in arrival order against the noted values
  always @(posedge rx_valid) begin
    if (exp_q.size() > 0) cmp16(rx_word, exp_q.pop_front());
  end

  // external error register clears on the strobe
  always @(posedge clock) begin
    if (err_clear === 1'b1) begin
      clr_seen++;
      err_word <= 16'h0000;
    end
  end

  initial begin
    #2000000;
    fail(16'h0001, 16'h0000);
    tally_and_finish();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [31:0] d;
    rst = 1'b0;
    err_word = 16'h0000;
    seed = 32'ha058a92a;
    // raise reset after time zero so the link's asynchronous clear sees a real edge
    #1;
    rst = 1'b1;
    repeat (12) @(negedge clock);
    rst = 1'b0;
    wr_reg(xmap_pkg::ADR_NULL, 16'hffff);
    for (int a = 0; a < 9; a++) rd_reg(7'(a), 16'h0000);
    rd_reg(7'h1f, 16'h0000);
    wr_reg(xmap_pkg::ADR_WR_TGT, 16'hffff);
    rd_reg(xmap_pkg::ADR_WR_TGT, 16'h00ff);
    wr_reg(xmap_pkg::ADR_RD_TGT, 16'hff5a);
    rd_reg(xmap_pkg::ADR_RD_TGT, 16'h005a);
    wr_reg(xmap_pkg::ADR_WR_CTL, 16'h7fff);
    rd_reg(xmap_pkg::ADR_WR_CTL, 16'h0000);
    wr_reg(xmap_pkg::ADR_RD_CTL, 16'h7fff);
    rd_reg(xmap_pkg::ADR_RD_CTL, 16'h0000);
    $display("test register_access done");
    foreach (tgts[k]) begin
      seed = xorshift(seed);
      d = seed;
      wr_reg(xmap_pkg::ADR_WR_HI, d[31:16]);
      wr_reg(xmap_pkg::ADR_WR_LO, d[15:0]);
      wr_reg(xmap_pkg::ADR_WR_TGT, {8'h00, tgts[k]});
      wr_reg(xmap_pkg::ADR_WR_CTL, 16'h8000);
      if (tgts[k] <= xmap_pkg::EE_LAST) begin
        @(negedge clock);
        cmp1(ext_write_busy, 1'b1);
        rd_reg(xmap_pkg::ADR_WR_CTL, 16'h0100);
      end
      wait_idle();
      rd_reg(xmap_pkg::ADR_WR_CTL, 16'h0001);
      wr_reg(xmap_pkg::ADR_RD_TGT, {8'h00, tgts[k]});
      wr_reg(xmap_pkg::ADR_RD_CTL, 16'h8000);
      if (tgts[k] <= xmap_pkg::EE_LAST) begin
        @(negedge clock);
        cmp1(ext_read_busy, 1'b1);
      end
      wait_idle();
      rd_reg(xmap_pkg::ADR_RD_CTL, 16'h0001);
      if (tgts[k] > xmap_pkg::MISC_LAST) d = 32'h0;
      rd_reg(xmap_pkg::ADR_RD_HI, d[31:16]);
      rd_reg(xmap_pkg::ADR_RD_LO, d[15:0]);
    end
    $display("test region_round_trip done");
    for (int k = 0; k < 3; k++) begin
      seed = xorshift(seed);
      @(negedge clock);
      err_word = seed[15:0];
      rd_reg(xmap_pkg::ADR_ERR, seed[15:0]);
      rd_reg(xmap_pkg::ADR_RD_LO, seed[15:0]);
    end
    cmp16(clr_seen[15:0], 16'h0003);
    $display("test error_snapshot done");
    tally_and_finish();
  end
endmodule : xmap_ext_mem_tb
